// file: design/reset_sequencer.sv
// Reset sequencer: merges reset sources and runs active, delay and fetch phases.
// Operation
// - Accept external pin, low-supply and watchdog resets.
// - Illegal opcode or prebyte also starts reset.
// - Internal sources drive pin; pin low during delay.
// - Phases run active, delay, then vector fetch.
// - Delay is 256 or 4096 clocks by option.
// - Vector fetch lasts exactly two clock cycles.
// - Core fetches start address from top vector.
// - Pin is input and open-drain output.
// - External reset detected only with a running clock, via synchroniser.
// - Oscillator keeps running throughout the reset phase.
// - Watchdog underflow drives pin low minimum width.
// - Low supply holds static reset, pin low.
`timescale 1ns/1ps
module reset_sequencer
    import reset_seq_pkg::*;
(
    input wire logic clock_i, // System clock, 20 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic rst_pin_i, // Reset pin level from the outside drive alone, without the device's own pull-down.
    output logic rst_pin_o, // Pad output value, always low.
    output logic rst_pin_oe_o, // Pad drive enable, high pulls the pin low.
    input wire logic low_supply_detector_i, // Low supply detected, active high.
    input wire logic wdg_underflow_i, // Watchdog underflow, one-cycle pulse.
    input wire logic illegal_op_i, // Illegal opcode or prebyte, one-cycle pulse.
    input wire logic long_delay_i, // Option: high selects the long delay.
    output logic osc_keep_o, // Oscillator enable, held high always.
    output logic core_reset_o, // Holds the core in reset.
    output logic vector_fetch_o, // High during the two fetch cycles.
    output logic [15:0] fetch_addr_o // Vector address presented in fetch.
);
    import reset_seq_pkg::*;

    seq_state_e state_r;
    seq_state_e state_nxt;
    logic [12:0] cnt_r;
    logic [12:0] cnt_nxt;
    logic [1:0] fetch_r;
    logic [1:0] fetch_nxt;
    logic [2:0] pin_sync_r;
    logic [2:0] sup_sync_r;
    logic pin_low_r;
    logic pin_low_nxt;
    logic sup_low_r;
    logic sup_low_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic any_src;
    logic illegal_hold_r;
    stretch_if st ();

    // Converts a option selection into the delay length.
    function automatic logic [12:0] delay_len(input logic long_sel);
        delay_len = long_sel ? DELAY_LONG : DELAY_SHORT;
    endfunction

    // Watchdog pulse is stretched so the pin stays low long enough.
    assign st.trigger = wdg_underflow_i;
    pulse_stretch u_stretch (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .st(st)
    );

    // Three-stage synchronisers for the pad and the supply detector.
    // The pad itself is a level, so a low pin must be caught by two successive edges before it holds reset.
    always_ff @(posedge clock_i)
    begin
        pin_sync_r <= {pin_sync_r[1:0], rst_pin_i};
        sup_sync_r <= {sup_sync_r[1:0], low_supply_detector_i};
    end

    // A change counts once stages two and three agree.
    always_comb
    begin
        pin_low_nxt = pin_low_r;
        sup_low_nxt = sup_low_r;
        if (pin_sync_r[1] == pin_sync_r[2])
        begin
            pin_low_nxt = ~pin_sync_r[2];
        end
        if (sup_sync_r[1] == sup_sync_r[2])
        begin
            sup_low_nxt = sup_sync_r[2];
        end
    end

    // Registers the filtered levels.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pin_low_r <= 1'b1;
            sup_low_r <= 1'b0;
        end
        else
        begin
            pin_low_r <= pin_low_nxt;
            sup_low_r <= sup_low_nxt;
        end
    end

    // Illegal opcode pulse is held for one cycle so it enters the active phase.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            illegal_hold_r <= 1'b0;
        end
        else
        begin
            illegal_hold_r <= illegal_op_i;
        end
    end

    // Any internal or external source holding reset active.
    assign any_src = pin_low_r | sup_low_r | st.active | wdg_underflow_i
        | illegal_op_i | illegal_hold_r;

    // Phase sequencing: active, delay, fetch, run.
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        fetch_nxt = fetch_r;
        addr_nxt = addr_r;
        if (any_src)
        begin
            state_nxt = ST_ACTIVE;
            cnt_nxt = 13'h0000;
            fetch_nxt = 2'h0;
        end
        else
        begin
            case (state_r)
                ST_ACTIVE:
                begin
                    state_nxt = ST_DELAY;
                    cnt_nxt = delay_len(long_delay_i);
                end
                ST_DELAY:
                begin
                    cnt_nxt = cnt_r - CNT_ONE;
                    if (cnt_r == CNT_ONE)
                    begin
                        state_nxt = ST_FETCH;
                        fetch_nxt = FETCH_CYCLES;
                        addr_nxt = VECTOR_ADDR;
                    end
                end
                ST_FETCH:
                begin
                    fetch_nxt = fetch_r - FETCH_ONE;
                    addr_nxt = VECTOR_ADDR + 16'h0001;
                    if (fetch_r == FETCH_ONE)
                    begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    state_nxt = ST_RUN;
                end
                default:
                begin
                    state_nxt = ST_ACTIVE;
                end
            endcase
        end
    end

    // Registers the sequencer state.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_ACTIVE;
            cnt_r <= 13'h0000;
            fetch_r <= 2'h0;
            addr_r <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            fetch_r <= fetch_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Pad drive: open drain, pulled low for internal sources and the delay.
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = sup_low_r | st.active | illegal_hold_r
        | (state_r == ST_DELAY);
    assign osc_keep_o = 1'b1;
    assign core_reset_o = (state_r != ST_RUN);
    assign vector_fetch_o = (state_r == ST_FETCH);
    assign fetch_addr_o = addr_r;

    // Checks on the phase sequence, the pad drive and the source handling.
    chk_delay_pin_low: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_r == ST_DELAY) |-> rst_pin_oe_o)
        else $error("Pin not driven low during delay.");
    chk_fetch_two: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(vector_fetch_o) && !any_src ##1 !any_src |-> vector_fetch_o ##1 !vector_fetch_o)
        else $error("Vector fetch did not last two cycles.");
    chk_fetch_addr: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(vector_fetch_o) |-> fetch_addr_o == VECTOR_ADDR)
        else $error("Wrong vector address.");
    chk_src_restart: assert property (@(posedge clock_i) disable iff (rst_i)
        any_src |=> state_r == ST_ACTIVE)
        else $error("Sequence did not restart on source.");
    chk_wdg_width: assert property (@(posedge clock_i) disable iff (rst_i)
        wdg_underflow_i |=> rst_pin_oe_o [*8])
        else $error("Watchdog pulse too short.");
    // The state register reacts one cycle after the filtered supply level rises.
    chk_supply_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        sup_low_r |-> rst_pin_oe_o ##1 core_reset_o)
        else $error("Low supply not holding reset.");
    chk_delay_load: assert property (@(posedge clock_i) disable iff (rst_i)
        state_r == ST_ACTIVE && !any_src |=> cnt_r == delay_len($past(long_delay_i)))
        else $error("Delay length wrong.");
    chk_phase_order: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(vector_fetch_o) |-> $past(state_r) == ST_DELAY)
        else $error("Fetch not preceded by delay.");
    chk_illegal_reset: assert property (@(posedge clock_i) disable iff (rst_i)
        illegal_op_i |=> rst_pin_oe_o && core_reset_o)
        else $error("Illegal opcode did not reset.");
    chk_osc_on: assert property (@(posedge clock_i) disable iff (rst_i)
        osc_keep_o)
        else $error("Oscillator stopped.");

    cov_run: cover property (@(posedge clock_i) disable iff (rst_i) $rose(state_r == ST_RUN));
    cov_wdg: cover property (@(posedge clock_i) disable iff (rst_i) wdg_underflow_i);
    cov_long: cover property (@(posedge clock_i) disable iff (rst_i)
        long_delay_i && $rose(state_r == ST_DELAY));
endmodule

// file: shared/reset_seq_pkg.sv
// Constants and types shared by the reset sequencer and its pulse stretcher.
package reset_seq_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam logic [12:0] DELAY_SHORT = 13'h0100;
    localparam logic [12:0] DELAY_LONG = 13'h1000;
    localparam logic [1:0] FETCH_CYCLES = 2'h2;
    localparam logic [15:0] VECTOR_ADDR = 16'hfffe;
    localparam logic [7:0] WDG_PULSE_CYCLES = 8'h10;
    localparam logic [12:0] CNT_ONE = 13'h0001;
    localparam logic [7:0] PULSE_ONE = 8'h01;
    localparam logic [1:0] FETCH_ONE = 2'h1;

    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_DELAY = 4'h2,
        ST_FETCH = 4'h4,
        ST_RUN = 4'h8
    } seq_state_e;
endpackage

// file: shared/stretch_if.sv
// Interface between the sequencer and its watchdog pulse stretcher.
`timescale 1ns/1ps
interface stretch_if;
    logic trigger;
    logic active;
    modport ctrl (output trigger, input active);
    modport unit (input trigger, output active);
endinterface

// file: design/pulse_stretch.sv
// Stretches a one-cycle watchdog event to the minimum output low width.
`timescale 1ns/1ps
module pulse_stretch
    import reset_seq_pkg::*;
(
    input wire logic clock_i, // System clock.
    input wire logic rst_i, // Synchronous reset, active high.
    stretch_if.unit st // Trigger in, stretched level out.
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // Reload on a trigger, otherwise count down to zero.
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (st.trigger)
        begin
            cnt_nxt = WDG_PULSE_CYCLES;
        end
        else if (cnt_r != 8'h00)
        begin
            cnt_nxt = cnt_r - PULSE_ONE;
        end
    end

    // Registers the count.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cnt_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    assign st.active = (cnt_r != 8'h00);
endmodule

// file: verif/ext_reset_model.sv
// Model of the outside reset circuitry on the open-drain reset pad.
`timescale 1ns/1ps
module ext_reset_model (
    input wire logic hold_low_i, // Request to pull the pad low.
    input wire logic dev_oe_i, // Device pulls the pad low.
    output logic ext_pin_o, // Level seen from the outside drive alone.
    output logic pad_o // Resolved pad level with weak pull-up.
);
    // Outside pulls low as long as asked, else the pull-up wins.
    assign ext_pin_o = hold_low_i ? 1'b0 : 1'b1;
    // Wired-AND of both open-drain drivers.
    assign pad_o = ext_pin_o & ~dev_oe_i;
endmodule

// file: verif/reset_sequencer_tb.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/1ps
module reset_sequencer_tb;
    import reset_seq_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic hold_low = 1'b0;
    logic supply_low = 1'b0;
    logic wdg = 1'b0;
    logic illegal = 1'b0;
    logic long_dly = 1'b0;
    logic ext_pin, pad, pin_oe, pin_val, osc_keep, core_rst, fetch;
    logic [15:0] addr;
    int n_errors = 0;
    int n_tests = 0;
    // Clock at 20 MHz.
    always #25 clock_i = ~clock_i;
    // The pin input sees only the outside drive, as the design expects.
    ext_reset_model partner (.hold_low_i(hold_low), .dev_oe_i(pin_oe),
        .ext_pin_o(ext_pin), .pad_o(pad));
    reset_sequencer DUT (.clock_i(clock_i), .rst_i(rst_i), .rst_pin_i(ext_pin),
        .rst_pin_o(pin_val), .rst_pin_oe_o(pin_oe), .low_supply_detector_i(supply_low),
        .wdg_underflow_i(wdg), .illegal_op_i(illegal), .long_delay_i(long_dly),
        .osc_keep_o(osc_keep), .core_reset_o(core_rst), .vector_fetch_o(fetch),
        .fetch_addr_o(addr));
    // Compares one value and counts it.
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Waits n edges and steps just past the last one.
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Measures the low-pad run before the fetch, then the fetch itself.
    task automatic run_check(input logic [12:0] n, input logic exact);
        int cnt = 0;
        for (int i = 0; i < 6000 && fetch !== 1'b1; i++)
        begin
            @(negedge clock_i);
            if (fetch !== 1'b1)
                cnt = (pin_oe === 1'b1 && pad === 1'b0) ? cnt + 1 : 0;
        end
        check("delay", exact ? 16'(cnt) : 16'(cnt >= n), exact ? 16'(n) : 16'h1);
        check("core1", 16'(core_rst), 16'h1);
        check("addr0", addr, VECTOR_ADDR);
        @(negedge clock_i);
        check("fetch2", 16'(fetch), 16'h1);
        check("addr1", addr, VECTOR_ADDR + 16'h1);
        @(negedge clock_i);
        check("run", {14'h0, fetch, core_rst}, 16'h0);
        check("pinval", 16'(pin_val), 16'h0);
        // Return just after a rising edge, so the next drive keeps to the stimulus timing.
        step(1);
    endtask
    // Sequence after the system reset, short delay.
    task automatic t_power;
        run_check(DELAY_SHORT, 1'b1);
        check("osc", 16'(osc_keep), 16'h1);
        $display("test power-up done");
    endtask
    // Outside pulse on the pin with either delay option.
    task automatic t_pin(input logic longd, input logic [12:0] n);
        long_dly = longd;
        hold_low = 1'b1;
        step(6);
        check("pin_core", 16'(core_rst), 16'h1);
        hold_low = 1'b0;
        run_check(n, 1'b1);
        check("osc2", 16'(osc_keep), 16'h1);
        long_dly = 1'b0;
        $display("test pin reset done");
    endtask
    // Watchdog underflow keeps the pad low, then sequences.
    task automatic t_wdg;
        int cnt = 0;
        wdg = 1'b1;
        step(1);
        wdg = 1'b0;
        step(2);
        repeat (14)
        begin
            @(negedge clock_i);
            cnt += (pad === 1'b0);
        end
        check("wdg_low", 16'(cnt), 16'd14);
        run_check(DELAY_SHORT, 1'b0);
        $display("test watchdog done");
    endtask
    // Illegal opcode in mid-delay restarts the whole delay.
    task automatic t_restart;
        hold_low = 1'b1;
        step(6);
        hold_low = 1'b0;
        step(100);
        illegal = 1'b1;
        step(1);
        illegal = 1'b0;
        step(2);
        check("ill_core", 16'(core_rst), 16'h1);
        run_check(DELAY_SHORT, 1'b0);
        $display("test restart done");
    endtask
    // Low supply holds a static reset with the pad low.
    task automatic t_supply;
        supply_low = 1'b1;
        step(40);
        check("sup_pad", {14'h0, pad, core_rst}, 16'h1);
        supply_low = 1'b0;
        run_check(DELAY_SHORT, 1'b0);
        $display("test supply done");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        step(10);
        rst_i = 1'b0;
        t_power();
        t_pin(1'b0, DELAY_SHORT);
        t_pin(1'b1, DELAY_LONG);
        t_wdg();
        t_restart();
        t_supply();
        give_verdict();
    end
    // Watchdog against a hang, well above the expected run.
    initial
    begin
        #2000000;
        n_errors++;
        give_verdict();
    end
endmodule
